// File: hw/smmu_top.sv
// page mmus for code and data sram plus the dma region mpu, with config port
`timescale 1ns/1ns
module smmu_top
  import smmu_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // configuration port
  input  wire logic        cfg_wr_i,
  input  wire logic        cfg_rd_i,
  input  wire logic [5:0]  cfg_idx_i,
  input  wire logic [31:0] cfg_wdata_i,
  input  wire logic [2:0]  cfg_process_id_i,
  output logic      [31:0] cfg_rdata_o,
  output logic             cfg_denied_o,
  // instruction bus
  input  wire logic        ibus_req_i,
  input  wire logic        ibus_we_i,
  input  wire logic [31:0] ibus_addr_i,
  input  wire logic [2:0]  ibus_process_id_i,
  input  wire logic [31:0] ibus_mem_rdata_i,
  output logic             ibus_mem_en_o,
  output logic             ibus_mem_we_o,
  output logic      [31:0] ibus_mem_addr_o,
  output logic             ibus_viol_o,
  output logic      [31:0] ibus_rdata_o,
  // data bus
  input  wire logic        dbus_req_i,
  input  wire logic        dbus_we_i,
  input  wire logic [31:0] dbus_addr_i,
  input  wire logic [2:0]  dbus_process_id_i,
  input  wire logic [31:0] dbus_mem_rdata_i,
  output logic             dbus_mem_en_o,
  output logic             dbus_mem_we_o,
  output logic      [31:0] dbus_mem_addr_o,
  output logic             dbus_viol_o,
  output logic      [31:0] dbus_rdata_o,
  // dma
  input  wire logic        dma_req_i,
  input  wire logic        dma_we_i,
  input  wire logic [31:0] dma_addr_i,
  input  wire logic [31:0] dma_mem_rdata_i,
  output logic             dma_mem_en_o,
  output logic             dma_mem_we_o,
  output logic      [31:0] dma_mem_addr_o,
  output logic             dma_viol_o,
  output logic      [31:0] dma_rdata_o
);

  // all three access ports share one timing: grant or refusal one cycle
  // after the request, read data two cycles after the grant; a refused
  // access or a write returns zero data. table writes land at their own
  // edge, so a request in the very next cycle already sees the new entry.
  // table reads are open to every process id; only writes are gated.

  // page tables: one entry per physical page
  logic [PAGES-1:0][6:0]   code_sram_page_map;
  logic [PAGES-1:0][6:0]   data_sram_page_map;
  // page size modes, two bits each; mode 3 behaves as 8 kb
  logic [1:0]              code_sram_page_size;
  logic [1:0]              data_sram_page_size;
  // dma permit bits, one per 8 kb region
  logic [31:0]             dma_region_permit_low;
  logic [8:0]              dma_region_permit_high;
  logic [DMA_REGIONS-1:0]  dma_permit_all;
  logic                    cfg_priv;
  // registered grant of a read, one per port, lines up the returned word
  logic                    ibus_ok_q;
  logic                    dbus_ok_q;
  logic                    dma_ok_q;
  // combinational decisions feeding the registered access stages
  smmu_xlate_t             ibus_x;
  smmu_xlate_t             dbus_x;
  logic                    dma_ok;

  // page shift from the size mode; an undefined mode falls back to 8 kb pages
  function automatic int smmu_shift(input logic [1:0] mode);
    int sh;
    sh = SHIFT_8K;
    if (mode == MODE_4K) begin
      sh = SHIFT_4K;
    end else if (mode == MODE_2K) begin
      sh = SHIFT_2K;
    end
    return sh;
  endfunction : smmu_shift

  // the two map banks are 16-entry blocks picked by the upper index bits
  function automatic logic smmu_is_code_map(input logic [5:0] idx);
    return idx[5:4] == IDX_CODE_MAP[5:4];
  endfunction : smmu_is_code_map

  // decoded on both the write and the read-back path, so kept in one place
  function automatic logic smmu_is_data_map(input logic [5:0] idx);
    return idx[5:4] == IDX_DATA_MAP[5:4];
  endfunction : smmu_is_data_map

  // permission, translation and coverage check for one mmu region
  function automatic smmu_xlate_t smmu_translate(
    input logic [31:0]           addr,
    input logic [31:0]           base,
    input logic [1:0]            mode,
    input logic [PAGES-1:0][6:0] map,
    input logic [2:0]            process_id,
    input logic                  wr,
    input logic                  code
  );
    smmu_xlate_t res;
    logic [31:0] off;
    logic [31:0] inpg;
    logic [3:0]  vp;
    logic [3:0]  pp;
    logic [2:0]  perm;
    logic        hit;
    int          sh;
    res.ok   = 1'b1;
    res.addr = addr;
    // below the base the offset wraps high, hence both bounds on the window test
    off      = addr - base;
    sh       = smmu_shift(mode);
    // virtual page and in-page offset both follow the page size mode
    vp       = 4'(off >> sh);
    inpg     = off & ((32'h0000_0001 << sh) - 32'h0000_0001);
    pp       = 4'h0;
    hit      = 1'b0;
    perm     = PERM_NONE;
    // outside the governed window the request passes untouched
    if (addr >= base && off < REGION_SIZE && process_id >= PID_FIRST_APP) begin
      res.ok = 1'b0;
      // uncovered tail and code writes stay refused for ids 2 to 7
      if ((off >> sh) < 32'(PAGES) && !(code && wr)) begin
        // downward scan so the lowest matching physical page wins
        for (int p = PAGES - 1; p >= 0; p--) begin
          perm = map[p][PERM_LSB +: 3];
          if (map[p][VPAGE_LSB +: 4] == vp && (perm == PERM_ALL || perm == process_id)) begin
            hit = 1'b1;
            pp  = 4'(p);
          end
        end
        // a match grants the access and moves it onto the physical page
        if (hit) begin
          res.ok   = 1'b1;
          res.addr = base + (32'(pp) << sh) + inpg;
        end
      end
    end
    // ids 0 and 1 keep the identity result set above
    return res;
  endfunction : smmu_translate

  // decode is combinational; the access stage below registers it
  assign ibus_x = smmu_translate(ibus_addr_i, CODE_BASE, code_sram_page_size, code_sram_page_map,
                                 ibus_process_id_i, ibus_we_i, 1'b1);
  assign dbus_x = smmu_translate(dbus_addr_i, DATA_BASE, data_sram_page_size, data_sram_page_map,
                                 dbus_process_id_i, dbus_we_i, 1'b0);

  // region bits in ascending address order, low register first
  assign dma_permit_all = {dma_region_permit_high, dma_region_permit_low};

  // no process id enters the dma decision at all; addresses below the base
  // or past the last region lie outside the mpu and pass untouched
  always_comb begin
    logic [31:0] doff;
    doff   = dma_addr_i - DMA_BASE;
    dma_ok = 1'b1;
    // bounding the offset keeps the region index inside the 41 permit bits
    if (dma_addr_i >= DMA_BASE && doff < (32'(DMA_REGIONS) << DMA_SHIFT)) begin
      dma_ok = dma_permit_all[6'(doff >> DMA_SHIFT)];
    end
  end

  // process ids 0 and 1 are the privileged callers
  assign cfg_priv = cfg_process_id_i < PID_FIRST_APP;

  // page table writes, privileged callers only
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_sram_page_map <= {PAGES{MAP_RESET}};
      data_sram_page_map <= {PAGES{MAP_RESET}};
    end else if (cfg_wr_i && cfg_priv) begin
      // one index names one entry, so a single write never touches both banks
      if (smmu_is_code_map(cfg_idx_i)) begin
        code_sram_page_map[cfg_idx_i[3:0]] <= cfg_wdata_i[6:0];
      end
      if (smmu_is_data_map(cfg_idx_i)) begin
        data_sram_page_map[cfg_idx_i[3:0]] <= cfg_wdata_i[6:0];
      end
    end
  end

  // page size and dma permit writes, privileged callers only
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      code_sram_page_size    <= SIZE_RESET;
      data_sram_page_size    <= SIZE_RESET;
      dma_region_permit_low  <= DMA_LOW_RESET;
      dma_region_permit_high <= DMA_HIGH_RESET;
    end else if (cfg_wr_i && cfg_priv) begin
      // narrow registers take the low bits of the write data
      case (cfg_idx_i)
        IDX_CODE_SIZE: code_sram_page_size    <= cfg_wdata_i[1:0];
        IDX_DATA_SIZE: data_sram_page_size    <= cfg_wdata_i[1:0];
        IDX_DMA_LOW:   dma_region_permit_low  <= cfg_wdata_i;
        IDX_DMA_HIGH:  dma_region_permit_high <= cfg_wdata_i[8:0];
        default: ;
      endcase
    end
  end

  // read-back and refused-write flag; reads are open to any process id
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_rdata_o  <= 32'h0000_0000;
      cfg_denied_o <= 1'b0;
    end else begin
      // the refusal pulse stands one cycle per dropped write
      cfg_denied_o <= cfg_wr_i && !cfg_priv;
      // a read and a write of one index in the same cycle return the old value
      if (cfg_rd_i) begin
        if (smmu_is_code_map(cfg_idx_i)) begin
          cfg_rdata_o <= {25'h0, code_sram_page_map[cfg_idx_i[3:0]]};
        end else if (smmu_is_data_map(cfg_idx_i)) begin
          cfg_rdata_o <= {25'h0, data_sram_page_map[cfg_idx_i[3:0]]};
        end else begin
          case (cfg_idx_i)
            IDX_CODE_SIZE: cfg_rdata_o <= {30'h0, code_sram_page_size};
            IDX_DATA_SIZE: cfg_rdata_o <= {30'h0, data_sram_page_size};
            IDX_DMA_LOW:   cfg_rdata_o <= dma_region_permit_low;
            IDX_DMA_HIGH:  cfg_rdata_o <= {23'h0, dma_region_permit_high};
            default:       cfg_rdata_o <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // instruction bus stage: a refused request never raises the memory enable
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ibus_mem_en_o   <= 1'b0;
      ibus_mem_we_o   <= 1'b0;
      ibus_mem_addr_o <= 32'h0000_0000;
      ibus_viol_o     <= 1'b0;
      ibus_ok_q       <= 1'b0;
      ibus_rdata_o    <= 32'h0000_0000;
    end else begin
      ibus_mem_en_o   <= ibus_req_i && ibus_x.ok;
      // ids 2 to 7 never get a code write through; the decode refuses it
      ibus_mem_we_o   <= ibus_req_i && ibus_x.ok && ibus_we_i;
      // the address is registered even when refused; only the enable qualifies it
      ibus_mem_addr_o <= ibus_x.addr;
      ibus_viol_o     <= ibus_req_i && !ibus_x.ok;
      // remember a granted read so the word returning next cycle is passed on
      ibus_ok_q       <= ibus_mem_en_o && !ibus_mem_we_o;
      ibus_rdata_o    <= ibus_ok_q ? ibus_mem_rdata_i : 32'h0000_0000;
    end
  end

  // data bus stage, same timing as the instruction bus
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dbus_mem_en_o   <= 1'b0;
      dbus_mem_we_o   <= 1'b0;
      dbus_mem_addr_o <= 32'h0000_0000;
      dbus_viol_o     <= 1'b0;
      dbus_ok_q       <= 1'b0;
      dbus_rdata_o    <= 32'h0000_0000;
    end else begin
      dbus_mem_en_o   <= dbus_req_i && dbus_x.ok;
      dbus_mem_we_o   <= dbus_req_i && dbus_x.ok && dbus_we_i;
      // the address is registered even when refused; only the enable qualifies it
      dbus_mem_addr_o <= dbus_x.addr;
      dbus_viol_o     <= dbus_req_i && !dbus_x.ok;
      // remember a granted read so the word returning next cycle is passed on
      dbus_ok_q       <= dbus_mem_en_o && !dbus_mem_we_o;
      dbus_rdata_o    <= dbus_ok_q ? dbus_mem_rdata_i : 32'h0000_0000;
    end
  end

  // dma stage: address is never translated, only gated by region bits
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dma_mem_en_o   <= 1'b0;
      dma_mem_we_o   <= 1'b0;
      dma_mem_addr_o <= 32'h0000_0000;
      dma_viol_o     <= 1'b0;
      dma_ok_q       <= 1'b0;
      dma_rdata_o    <= 32'h0000_0000;
    end else begin
      dma_mem_en_o   <= dma_req_i && dma_ok;
      // dma writes need only the region bit, never a process id
      dma_mem_we_o   <= dma_req_i && dma_ok && dma_we_i;
      // the address is registered even when refused; only the enable qualifies it
      dma_mem_addr_o <= dma_addr_i;
      dma_viol_o     <= dma_req_i && !dma_ok;
      // remember a granted read so the word returning next cycle is passed on
      dma_ok_q       <= dma_mem_en_o && !dma_mem_we_o;
      dma_rdata_o    <= dma_ok_q ? dma_mem_rdata_i : 32'h0000_0000;
    end
  end

endmodule : smmu_top

// File: pkg/smmu_pkg.sv
// constants and types for the internal sram page mmus and the dma region mpu
// Functional notes
// - each mmu holds exactly sixteen page registers for permission and translation
// - page registers are indexed by physical page and name the virtual page
// - process ids 0 and 1 bypass tables: full access, page x maps to x
// - bits 6:4: 0 denies ids 2-7, 1 admits all, 2-7 admit that id
// - bits 3:0 name the virtual page landing here at same in-page offset
// - page and page-size registers are writable only by process id 0 or 1
// - code mmu sits on the instruction bus, data mmu on the data bus
// - ids 2-7 may only read code pages; their writes never reach memory
// - ids 2-7 may read and write data pages subject to the permission code
// - data page n starts at base plus n times page size; rest uncovered
// - dma mpu keeps one permit bit per 8 kb region
// - dma decision uses region bits only, never a process id
// - bit set lets dma read and write the region; clear refuses it
// - region bits ascend from the low area start through both registers
// - low register bits 9-24 cover data sram, bits 0-8 and bit 25 onward the other areas
// - both dma permit registers are writable only by process id 0 or 1
// - page-size modes 0, 1, 2 give 8, 4, 2 kb pages, sixteen pages each
// - uncovered area is open to ids 0 and 1 and closed to all others
package smmu_pkg;
  localparam logic [31:0] CODE_BASE     = 32'h4008_0000;
  localparam logic [31:0] DATA_BASE     = 32'h3FFC_0000;
  localparam logic [31:0] REGION_SIZE   = 32'h0002_0000;
  localparam logic [31:0] DMA_BASE      = 32'h3FFA_E000;
  localparam int          DMA_SHIFT     = 13;
  localparam int          DMA_REGIONS   = 41;
  localparam int          PAGES         = 16;
  localparam int          PERM_LSB      = 4;
  localparam int          VPAGE_LSB     = 0;
  localparam logic [1:0]  MODE_8K       = 2'h0;
  localparam logic [1:0]  MODE_4K       = 2'h1;
  localparam logic [1:0]  MODE_2K       = 2'h2;
  localparam int          SHIFT_8K      = 13;
  localparam int          SHIFT_4K      = 12;
  localparam int          SHIFT_2K      = 11;
  localparam logic [2:0]  PERM_NONE     = 3'h0;
  localparam logic [2:0]  PERM_ALL      = 3'h1;
  localparam logic [2:0]  PID_FIRST_APP = 3'h2;
  // register indices on the configuration port
  localparam logic [5:0]  IDX_CODE_MAP  = 6'h00;
  localparam logic [5:0]  IDX_DATA_MAP  = 6'h10;
  localparam logic [5:0]  IDX_CODE_SIZE = 6'h20;
  localparam logic [5:0]  IDX_DATA_SIZE = 6'h21;
  localparam logic [5:0]  IDX_DMA_LOW   = 6'h22;
  localparam logic [5:0]  IDX_DMA_HIGH  = 6'h23;
  localparam logic [6:0]  MAP_RESET     = 7'h00;
  localparam logic [1:0]  SIZE_RESET    = 2'h0;
  localparam logic [31:0] DMA_LOW_RESET = 32'h0000_0000;
  localparam logic [8:0]  DMA_HIGH_RESET = 9'h000;

  typedef struct packed {
    logic        ok;
    logic [31:0] addr;
  } smmu_xlate_t;
endpackage : smmu_pkg

// File: sim/smmu_mem_model.sv
// sram responder behind one access port
`timescale 1ns/1ns
module smmu_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic        mem_en_i,
  input  wire logic [31:0] mem_addr_i,
  output logic      [31:0] mem_rdata_o
);
  // data follows the address; idle cycles toggle so stale data never looks valid
  always_ff @(posedge clk_sys_i) begin
    if (mem_en_i) mem_rdata_o <= mem_addr_i ^ 32'hA5A5_0000;
    else mem_rdata_o <= ~mem_rdata_o;
  end
endmodule : smmu_mem_model

// File: sim/smmu_props.sv
// concurrent checks on the sram page mmu and dma mpu ports
`timescale 1ns/1ns
module smmu_props
  import smmu_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        reset_n_i,
  input wire logic        cfg_wr_i,
  input wire logic [2:0]  cfg_process_id_i,
  input wire logic        cfg_denied_o,
  input wire logic        ibus_req_i,
  input wire logic        ibus_we_i,
  input wire logic [31:0] ibus_addr_i,
  input wire logic [2:0]  ibus_process_id_i,
  input wire logic        ibus_mem_en_o,
  input wire logic        ibus_mem_we_o,
  input wire logic [31:0] ibus_mem_addr_o,
  input wire logic        ibus_viol_o,
  input wire logic [31:0] ibus_rdata_o,
  input wire logic [31:0] dbus_addr_i,
  input wire logic [31:0] dbus_mem_rdata_i,
  input wire logic        dbus_mem_en_o,
  input wire logic        dbus_mem_we_o,
  input wire logic [31:0] dbus_mem_addr_o,
  input wire logic [31:0] dbus_rdata_o,
  input wire logic        dma_req_i,
  input wire logic [31:0] dma_addr_i,
  input wire logic        dma_mem_en_o,
  input wire logic [31:0] dma_mem_addr_o,
  input wire logic        dma_viol_o
);
  // one clock domain, so clocking and reset are given once
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  property p_cfg_deny; cfg_wr_i && cfg_process_id_i > 3'h1 |=> cfg_denied_o; endproperty
  a_cfg_deny: assert property (p_cfg_deny) else $error("unprivileged config write not flagged");
  property p_cfg_priv; cfg_wr_i && cfg_process_id_i <= 3'h1 |=> !cfg_denied_o; endproperty
  a_cfg_priv: assert property (p_cfg_priv) else $error("privileged config write flagged");
  property p_ibus_ident;
    ibus_req_i && ibus_process_id_i <= 3'h1 |=> ibus_mem_en_o && ibus_mem_addr_o == $past(ibus_addr_i);
  endproperty
  a_ibus_ident: assert property (p_ibus_ident) else $error("privileged fetch not passed unchanged");
  property p_ibus_ro;
    ibus_req_i && ibus_we_i && ibus_process_id_i > 3'h1 && ibus_addr_i[31:17] == CODE_BASE[31:17]
      |=> !ibus_mem_we_o && ibus_viol_o;
  endproperty
  a_ibus_ro: assert property (p_ibus_ro) else $error("application write reached code sram");
  property p_ibus_zero; ibus_viol_o |=> ##1 ibus_rdata_o == 32'h0; endproperty
  a_ibus_zero: assert property (p_ibus_zero) else $error("refused fetch returned data");
  // 2 kb is the smallest page, so the low 11 bits always survive translation
  property p_dbus_ofs; dbus_mem_en_o |-> dbus_mem_addr_o[10:0] == $past(dbus_addr_i[10:0]); endproperty
  a_dbus_ofs: assert property (p_dbus_ofs) else $error("in-page offset altered");
  property p_dbus_pass; dbus_mem_en_o && !dbus_mem_we_o |-> ##2 dbus_rdata_o == $past(dbus_mem_rdata_i); endproperty
  a_dbus_pass: assert property (p_dbus_pass) else $error("granted data read lost");
  property p_dma_one; dma_req_i |=> dma_mem_en_o ^ dma_viol_o; endproperty
  a_dma_one: assert property (p_dma_one) else $error("dma request neither granted nor refused");
  property p_dma_addr; dma_mem_en_o |-> dma_mem_addr_o == $past(dma_addr_i); endproperty
  a_dma_addr: assert property (p_dma_addr) else $error("dma address altered");
  c_cfg_deny: cover property (cfg_denied_o);
  c_ibus_viol: cover property (ibus_viol_o);
  c_dma_viol: cover property (dma_viol_o);
endmodule : smmu_props
bind smmu_top smmu_props u_smmu_props (.*);

// File: sim/testbench.sv
// self-checking bench: config port, translation, permissions, dma regions
`timescale 1ns/1ns
module testbench;
  import smmu_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic        cfg_wr, cfg_rd, we, cfg_denied;
  logic [5:0]  cfg_idx;
  logic [2:0]  cfg_pid, process_id, req;
  wire  [2:0]  en, mwe, viol;
  logic [31:0] cfg_wdata, cfg_rdata, addr;
  wire  [31:0] maddr [3];
  wire  [31:0] rdata [3];
  wire  [31:0] mrd [3];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  initial forever #4 clk_sys_i = ~clk_sys_i;
  smmu_top u_smmu_top (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
    .cfg_idx_i(cfg_idx), .cfg_wdata_i(cfg_wdata), .cfg_process_id_i(cfg_pid), .cfg_rdata_o(cfg_rdata),
    .cfg_denied_o(cfg_denied), .ibus_req_i(req[0]), .ibus_we_i(we), .ibus_addr_i(addr), .ibus_process_id_i(process_id),
    .ibus_mem_rdata_i(mrd[0]), .ibus_mem_en_o(en[0]), .ibus_mem_we_o(mwe[0]), .ibus_mem_addr_o(maddr[0]),
    .ibus_viol_o(viol[0]), .ibus_rdata_o(rdata[0]), .dbus_req_i(req[1]), .dbus_we_i(we), .dbus_addr_i(addr),
    .dbus_process_id_i(process_id), .dbus_mem_rdata_i(mrd[1]), .dbus_mem_en_o(en[1]), .dbus_mem_we_o(mwe[1]),
    .dbus_mem_addr_o(maddr[1]), .dbus_viol_o(viol[1]), .dbus_rdata_o(rdata[1]), .dma_req_i(req[2]),
    .dma_we_i(we), .dma_addr_i(addr), .dma_mem_rdata_i(mrd[2]), .dma_mem_en_o(en[2]), .dma_mem_we_o(mwe[2]),
    .dma_mem_addr_o(maddr[2]), .dma_viol_o(viol[2]), .dma_rdata_o(rdata[2]));
  for (genvar g = 0; g < 3; g++) begin : g_mem
    smmu_mem_model u_smmu_mem_model (.clk_sys_i(clk_sys_i), .mem_en_i(en[g]), .mem_addr_i(maddr[g]),
      .mem_rdata_o(mrd[g]));
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cfg_w(input logic [5:0] i, input logic [31:0] d, input logic [2:0] p, input logic deny);
    @(posedge clk_sys_i);
    cfg_wr <= 1'b1;
    cfg_idx <= i;
    cfg_wdata <= d;
    cfg_pid <= p;
    @(posedge clk_sys_i);
    cfg_wr <= 1'b0;
    #1 chk({31'h0, cfg_denied}, {31'h0, deny});
  endtask : cfg_w
  task automatic cfg_r(input logic [5:0] i, input logic [31:0] exp);
    @(posedge clk_sys_i);
    cfg_rd <= 1'b1;
    cfg_idx <= i;
    @(posedge clk_sys_i);
    cfg_rd <= 1'b0;
    #1 chk(cfg_rdata, exp);
  endtask : cfg_r
  // one access on port b (0 code, 1 data, 2 dma); pa is the expected physical address
  task automatic acc(input int b, input logic w, input logic [31:0] a, input logic [2:0] p, input logic ok,
                     input logic [31:0] pa);
    @(posedge clk_sys_i);
    req[b] <= 1'b1;
    we <= w;
    addr <= a;
    process_id <= p;
    @(posedge clk_sys_i);
    req[b] <= 1'b0;
    #1 chk({29'h0, en[b], mwe[b], viol[b]}, {29'h0, ok, ok & w, ~ok});
    if (ok) chk(maddr[b], pa);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(rdata[b], (ok && !w) ? (pa ^ 32'hA5A5_0000) : 32'h0);
  endtask : acc
  task automatic t_reset_values;
    logic [5:0] ix [9] = '{6'h00, 6'h0F, 6'h10, 6'h1F, 6'h20, 6'h21, 6'h22, 6'h23, 6'h24};
    foreach (ix[k]) cfg_r(ix[k], 32'h0);
  endtask : t_reset_values
  task automatic t_cfg_priv;
    cfg_w(IDX_DMA_LOW, 32'hFFFF_FFFF, 3'h3, 1'b1);
    cfg_r(IDX_DMA_LOW, 32'h0);
    cfg_w(IDX_DATA_SIZE, 32'h2, 3'h7, 1'b1);
    cfg_r(IDX_DATA_SIZE, 32'h0);
    cfg_w(IDX_DATA_MAP + 6'h2, 32'h11, 3'h1, 1'b0);
    cfg_r(IDX_DATA_MAP + 6'h2, 32'h11);
    cfg_w(IDX_CODE_MAP + 6'h5, 32'hFF, 3'h0, 1'b0);
    cfg_r(IDX_CODE_MAP + 6'h5, 32'h7F);
    cfg_w(IDX_DMA_HIGH, 32'hFFFF_FFFF, 3'h0, 1'b0);
    cfg_r(IDX_DMA_HIGH, 32'h1FF);
  endtask : t_cfg_priv
  task automatic t_translate;
    acc(1, 1'b0, 32'h3FFC_2345, 3'h1, 1'b1, 32'h3FFC_2345);
    acc(0, 1'b1, 32'h4008_0104, 3'h0, 1'b1, 32'h4008_0104);
    acc(1, 1'b0, 32'h3FFC_2345, 3'h4, 1'b1, 32'h3FFC_4345);
    acc(1, 1'b1, 32'h3FFC_2345, 3'h4, 1'b1, 32'h3FFC_4345);
    acc(1, 1'b0, 32'h3FFC_0010, 3'h2, 1'b0, 32'h0);
    cfg_w(IDX_DATA_MAP + 6'h3, 32'h56, 3'h0, 1'b0);
    acc(1, 1'b1, 32'h3FFC_C010, 3'h5, 1'b1, 32'h3FFC_6010);
    acc(1, 1'b1, 32'h3FFC_C010, 3'h4, 1'b0, 32'h0);
    cfg_w(IDX_DATA_MAP + 6'h4, 32'h1C, 3'h0, 1'b0);
    acc(1, 1'b0, 32'h3FFD_8010, 3'h2, 1'b1, 32'h3FFC_8010);
  endtask : t_translate
  task automatic t_page_size;
    cfg_w(IDX_DATA_SIZE, 32'h2, 3'h0, 1'b0);
    acc(1, 1'b0, 32'h3FFC_0834, 3'h4, 1'b1, 32'h3FFC_1034);
    acc(1, 1'b0, 32'h3FFC_8000, 3'h4, 1'b0, 32'h0);
    acc(1, 1'b1, 32'h3FFC_8000, 3'h0, 1'b1, 32'h3FFC_8000);
    cfg_w(IDX_DATA_SIZE, 32'h1, 3'h1, 1'b0);
    acc(1, 1'b0, 32'h3FFC_1034, 3'h4, 1'b1, 32'h3FFC_2034);
    acc(1, 1'b0, 32'h3FFD_0000, 3'h3, 1'b0, 32'h0);
  endtask : t_page_size
  task automatic t_code;
    cfg_w(IDX_CODE_MAP + 6'h1, 32'h10, 3'h0, 1'b0);
    acc(0, 1'b0, 32'h4008_0100, 3'h3, 1'b1, 32'h4008_2100);
    acc(0, 1'b1, 32'h4008_0100, 3'h3, 1'b0, 32'h0);
  endtask : t_code
  task automatic t_dma;
    cfg_w(IDX_DMA_LOW, 32'h0200_0001, 3'h1, 1'b0);
    cfg_w(IDX_DMA_HIGH, 32'h100, 3'h0, 1'b0);
    acc(2, 1'b0, 32'h3FFA_E004, 3'h0, 1'b1, 32'h3FFA_E004);
    acc(2, 1'b1, 32'h3FFB_0000, 3'h0, 1'b0, 32'h0);
    acc(2, 1'b0, 32'h3FFD_E000, 3'h0, 1'b0, 32'h0);
    acc(2, 1'b1, 32'h3FFE_0010, 3'h6, 1'b1, 32'h3FFE_0010);
    acc(2, 1'b0, 32'h3FFF_E008, 3'h0, 1'b1, 32'h3FFF_E008);
    acc(2, 1'b0, 32'h3FFF_C000, 3'h0, 1'b0, 32'h0);
    acc(2, 1'b0, 32'h4008_0000, 3'h0, 1'b1, 32'h4008_0000);
  endtask : t_dma
  task automatic tally_and_finish;
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // hang guard: the whole sequence needs well under 1000 cycles
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    {cfg_wr, cfg_rd, we, req, cfg_idx, cfg_pid, process_id} <= '0;
    {cfg_wdata, addr} <= '0;
    repeat (2) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset_values();
    t_cfg_priv();
    t_translate();
    t_page_size();
    t_code();
    t_dma();
    tally_and_finish();
  end
endmodule : testbench
